// file: src/nvsq_host.sv
// Host controller for a nonvolatile SRAM: plain reads and writes, and
// the six-read software sequence that launches a STORE or a RECALL.
// Assumes the memory pins are outside this clock domain and that
// supply_ok comes from a supply monitor on another domain.
`default_nettype none

module nvsq_host
#(
    parameter int STORE_WAIT   = nvsq_pkg::STORE_CYC + nvsq_pkg::NV_FLOAT_CYC,
    parameter int RESTORE_WAIT = nvsq_pkg::RESTORE_CYC
)
(
    // Clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          nrst,
    // Command port
    input  wire logic                          cmd_valid,
    input  wire nvsq_pkg::nvsq_op_t            cmd_op,
    input  wire logic [nvsq_pkg::ADDR_W-1:0]   cmd_addr,
    input  wire logic [nvsq_pkg::DATA_W-1:0]   cmd_wdata,
    output logic                               cmd_ready,
    output logic                               done,
    output logic [nvsq_pkg::DATA_W-1:0]        rdata,
    output logic                               busy,
    // Supply monitor
    input  wire logic                          supply_ok,
    // Memory pins
    output logic [nvsq_pkg::ADDR_W-1:0]        addr_bus,
    input  wire logic [nvsq_pkg::DATA_W-1:0]   data_bus_i,
    output logic [nvsq_pkg::DATA_W-1:0]        data_bus_o,
    output logic                               data_bus_oe,
    output logic                               chip_enable_n,
    output logic                               write_enable_n,
    output logic                               output_enable_n
);

    typedef enum logic [2:0] {
        ST_POWER,
        ST_RESTORE,
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_RECOVER,
        ST_NV_WAIT
    } nvsq_state_t;

    localparam int STROBE_LOAD = nvsq_pkg::STROBE_CYC - 1;
    localparam int RECALL_WAIT = nvsq_pkg::RECALL_CYC + nvsq_pkg::NV_FLOAT_CYC;

    // Address of each sequence step; only the two legal sixth addresses exist
    function automatic logic [nvsq_pkg::ADDR_W-1:0] seq_addr(input logic [2:0] step,
                                                              input logic       recall);
        case (step)
            3'h0:    seq_addr = nvsq_pkg::SEQ_A0;
            3'h1:    seq_addr = nvsq_pkg::SEQ_A1;
            3'h2:    seq_addr = nvsq_pkg::SEQ_A2;
            3'h3:    seq_addr = nvsq_pkg::SEQ_A3;
            3'h4:    seq_addr = nvsq_pkg::SEQ_A4;
            default: seq_addr = recall ? nvsq_pkg::SEQ_RECALL
                                       : nvsq_pkg::SEQ_STORE;
        endcase
    endfunction

    logic                        rst_meta_q;
    logic                        rst_n_q;
    logic                        sup_meta_q;
    logic                        sup_q;
    logic [nvsq_pkg::DATA_W-1:0] din_meta_q;
    logic [nvsq_pkg::DATA_W-1:0] din_q;

    nvsq_state_t                 state_q;
    logic [2:0]                  step_q;
    logic                        seq_q;
    logic                        recall_q;
    logic                        is_read_q;

    nvsq_tmr_if tmr ();

    nvsq_timer u_timer
    (
        .clk   (core_clk),
        .rst_n (rst_n_q),
        .tmr   (tmr)
    );

    // Reset release
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Pin and supply synchronisers
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            sup_meta_q <= 1'b0;
            sup_q      <= 1'b0;
            din_meta_q <= '0;
            din_q      <= '0;
        end
        else
        begin
            sup_meta_q <= supply_ok;
            sup_q      <= sup_meta_q;
            din_meta_q <= data_bus_i;
            din_q      <= din_meta_q;
        end
    end

    // Timer loads for strobe width and wait times
    always_comb
    begin
        tmr.load  = 1'b0;
        tmr.value = '0;
        case (state_q)
            ST_POWER:
                if (sup_q)
                begin
                    tmr.load  = 1'b1;
                    tmr.value = nvsq_pkg::CNT_W'(RESTORE_WAIT);
                end
            ST_SETUP:
            begin
                tmr.load  = 1'b1;
                tmr.value = nvsq_pkg::CNT_W'(STROBE_LOAD);
            end
            ST_RECOVER:
                if (seq_q && step_q == nvsq_pkg::SEQ_LAST)
                begin
                    tmr.load  = 1'b1;
                    tmr.value = recall_q ? nvsq_pkg::CNT_W'(RECALL_WAIT)
                                         : nvsq_pkg::CNT_W'(STORE_WAIT);
                end
            default:
            begin
                tmr.load  = 1'b0;
                tmr.value = '0;
            end
        endcase
    end

    // Sequencer and pins
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q         <= ST_POWER;
            step_q          <= 3'h0;
            seq_q           <= 1'b0;
            recall_q        <= 1'b0;
            is_read_q       <= 1'b0;
            cmd_ready       <= 1'b0;
            busy            <= 1'b1;
            done            <= 1'b0;
            rdata           <= '0;
            addr_bus        <= '0;
            data_bus_o      <= '0;
            data_bus_oe     <= 1'b0;
            chip_enable_n   <= 1'b1;
            write_enable_n  <= 1'b1;
            output_enable_n <= 1'b1;
        end
        else
        begin
            done <= 1'b0;
            case (state_q)
                ST_POWER:
                    if (sup_q)
                        state_q <= ST_RESTORE;
                ST_RESTORE:
                    if (tmr.expired)
                    begin
                        // Supply low when the wait ends: the power-up wait starts over
                        state_q   <= sup_q ? ST_IDLE : ST_POWER;
                        cmd_ready <= sup_q;
                        busy      <= !sup_q;
                    end
                ST_IDLE:
                    if (!sup_q)
                    begin
                        // Low supply: stop taking commands, store cannot start
                        state_q   <= ST_POWER;
                        cmd_ready <= 1'b0;
                        busy      <= 1'b1;
                    end
                    else if (cmd_valid)
                    begin
                        cmd_ready <= 1'b0;
                        state_q   <= ST_SETUP;
                        step_q    <= 3'h0;
                        is_read_q <= (cmd_op == nvsq_pkg::NVSQ_OP_READ);
                        recall_q  <= (cmd_op == nvsq_pkg::NVSQ_OP_RECALL);
                        if (cmd_op == nvsq_pkg::NVSQ_OP_STORE ||
                            cmd_op == nvsq_pkg::NVSQ_OP_RECALL)
                        begin
                            seq_q    <= 1'b1;
                            busy     <= 1'b1;
                            addr_bus <= nvsq_pkg::SEQ_A0;
                        end
                        else
                        begin
                            seq_q    <= 1'b0;
                            addr_bus <= cmd_addr;
                        end
                        if (cmd_op == nvsq_pkg::NVSQ_OP_WRITE)
                        begin
                            // Write enable ahead of chip enable keeps the device quiet
                            write_enable_n <= 1'b0;
                            data_bus_o     <= cmd_wdata;
                            data_bus_oe    <= 1'b1;
                        end
                        // Sequence reads leave output enable high
                        output_enable_n <= (cmd_op != nvsq_pkg::NVSQ_OP_READ);
                    end
                ST_SETUP:
                begin
                    chip_enable_n <= 1'b0;
                    state_q       <= ST_STROBE;
                end
                ST_STROBE:
                    if (tmr.expired)
                    begin
                        chip_enable_n <= 1'b1;
                        if (is_read_q)
                            rdata <= din_q;
                        state_q <= ST_RECOVER;
                    end
                ST_RECOVER:
                begin
                    // Address moves only now, one cycle after enable rose
                    write_enable_n  <= 1'b1;
                    data_bus_oe     <= 1'b0;
                    output_enable_n <= 1'b1;
                    if (seq_q && step_q != nvsq_pkg::SEQ_LAST)
                    begin
                        step_q   <= step_q + 3'h1;
                        addr_bus <= seq_addr(step_q + 3'h1, recall_q);
                        state_q  <= ST_SETUP;
                    end
                    else if (seq_q)
                        state_q <= ST_NV_WAIT;
                    else
                    begin
                        done      <= 1'b1;
                        cmd_ready <= 1'b1;
                        state_q   <= ST_IDLE;
                    end
                end
                ST_NV_WAIT:
                    if (tmr.expired)
                    begin
                        // Ready after the wait follows sup_q, so no store can follow on low supply
                        done      <= 1'b1;
                        cmd_ready <= sup_q;
                        busy      <= !sup_q;
                        seq_q     <= 1'b0;
                        state_q   <= sup_q ? ST_IDLE : ST_POWER;
                    end
                default:
                    state_q <= ST_POWER;
            endcase
        end
    end

endmodule

`default_nettype wire

// file: pkg/nvsq_pkg.sv
// Constants shared by the nonvolatile sequence host and its timer.
// Assumes a single 40 MHz clock; all times are turned into cycle counts here.
`default_nettype none

package nvsq_pkg;

    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 24;
    localparam int SYNC_STAGES = 2;

    localparam int CLK_HZ  = 40_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;

    // Times as printed, for the slowest speed grade
    localparam int ACCESS_NS      = 45;
    localparam int SEQ_PULSE_NS   = 35;
    localparam int NV_FLOAT_NS    = 600;
    localparam int STORE_TIME_MS  = 10;
    localparam int RECALL_TIME_US = 20;
    localparam int RESTORE_US     = 650;

    // Least times round up, longest times are waited in full
    localparam int ACCESS_CYC   = (ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int SEQ_PULSE_CYC = (SEQ_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int NV_FLOAT_CYC = (NV_FLOAT_NS * CLK_MHZ + 999) / 1000;
    localparam int STORE_CYC    = STORE_TIME_MS * (CLK_HZ / 1000);
    localparam int RECALL_CYC   = RECALL_TIME_US * CLK_MHZ;
    localparam int RESTORE_CYC  = RESTORE_US * CLK_MHZ;

    // Enable low long enough for access time plus the data synchroniser
    localparam int STROBE_CYC = ((ACCESS_CYC > SEQ_PULSE_CYC) ? ACCESS_CYC : SEQ_PULSE_CYC)
                                + SYNC_STAGES + 1;

    localparam int SEQ_LEN = 6;
    localparam logic [2:0] SEQ_LAST = 3'h5;

    localparam logic [ADDR_W-1:0] SEQ_A0      = 13'h0000;
    localparam logic [ADDR_W-1:0] SEQ_A1      = 13'h1555;
    localparam logic [ADDR_W-1:0] SEQ_A2      = 13'h0aaa;
    localparam logic [ADDR_W-1:0] SEQ_A3      = 13'h1fff;
    localparam logic [ADDR_W-1:0] SEQ_A4      = 13'h10f0;
    localparam logic [ADDR_W-1:0] SEQ_STORE   = 13'h0f0f;
    localparam logic [ADDR_W-1:0] SEQ_RECALL  = 13'h0f0e;

    typedef enum logic [1:0] {
        NVSQ_OP_READ,
        NVSQ_OP_WRITE,
        NVSQ_OP_STORE,
        NVSQ_OP_RECALL
    } nvsq_op_t;

endpackage

`default_nettype wire

// file: pkg/nvsq_tmr_if.sv
// Load and expiry handshake between the sequencer and its down counter.
// Assumes both ends share one clock.
`default_nettype none

interface nvsq_tmr_if;
    logic                        load;
    logic [nvsq_pkg::CNT_W-1:0]  value;
    logic                        expired;

    modport ctrl  (output load, output value, input expired);
    modport timer (input load, input value, output expired);
endinterface

`default_nettype wire

// file: src/nvsq_timer.sv
// Down counter used for strobe widths and nonvolatile wait times.
// Assumes an asynchronous active-low reset whose release the top has already synchronised.
`default_nettype none

module nvsq_timer
(
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst_n,
    // Control
    nvsq_tmr_if.timer  tmr
);

    logic [nvsq_pkg::CNT_W-1:0] count_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            count_q <= '0;
        else if (tmr.load)
            count_q <= tmr.value;
        else if (count_q != '0)
            count_q <= count_q - 1'b1;
    end

    // A fresh load always wins over a stale zero
    assign tmr.expired = (count_q == '0) && !tmr.load;

endmodule

`default_nettype wire

// file: tb/nvsq_host_props.sv
// Checker on the host controller pins: sequence, strobe and command timing.
// Assumes the host's single 40 MHz clock and its active-low reset.
`default_nettype none

module nvsq_host_props
(
    // Clock and reset
    input wire logic                        core_clk,
    input wire logic                        nrst,
    // Command side
    input wire logic                        cmd_valid,
    input wire logic                        cmd_ready,
    input wire logic                        done,
    input wire logic                        busy,
    input wire logic                        supply_ok,
    // Memory pins
    input wire logic [nvsq_pkg::ADDR_W-1:0] addr_bus,
    input wire logic                        data_bus_oe,
    input wire logic                        chip_enable_n,
    input wire logic                        write_enable_n,
    input wire logic                        output_enable_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    we_high_a: assert property (busy |-> write_enable_n)
        else $error("write strobe low during sequence");
    oe_high_a: assert property (busy |-> output_enable_n)
        else $error("output enable low during sequence");
    seq_no_drive_a: assert property (busy |-> !data_bus_oe)
        else $error("host drives data during sequence");
    addr_hold_a: assert property (!chip_enable_n |-> $stable(addr_bus))
        else $error("address moved while enable low");
    pulse_width_a: assert property ($fell(chip_enable_n) |->
        !chip_enable_n[*5] ##1 chip_enable_n) else $error("enable pulse width wrong");
    pulse_gap_a: assert property ($rose(chip_enable_n) |-> chip_enable_n[*2])
        else $error("enable high gap too short");
    test_addr_a: assert property (busy && !chip_enable_n |-> addr_bus != 13'h139c)
        else $error("reserved address issued");
    write_order_a: assert property ($fell(chip_enable_n) && data_bus_oe |->
        !write_enable_n) else $error("write strobe late");
    done_lat_a: assert property ($fell(cmd_ready) && $past(cmd_valid) && !busy |->
        ##7 done) else $error("access done latency wrong");
    supply_gate_a: assert property (!supply_ok[*5] |-> !cmd_ready)
        else $error("ready while supply low");

    cover property ($fell(busy));
    cover property ($rose(data_bus_oe));
    cover property (!supply_ok ##1 !cmd_ready);
endmodule

bind nvsq_host nvsq_host_props u_nvsq_host_props (.core_clk, .nrst, .cmd_valid, .cmd_ready,
    .done, .busy, .supply_ok, .addr_bus, .data_bus_oe, .chip_enable_n, .write_enable_n,
    .output_enable_n);

`default_nettype wire

// file: tb/nvsq_mem_model.sv
// Behavioural nonvolatile SRAM driven by enable edges; counts stores, recalls and early accesses.
// Assumes the bench resolves the shared data lines from the host's enable.
`default_nettype none

module nvsq_mem_model
#(
    parameter int STORE_NS   = 10_000_000,
    parameter int RECALL_NS  = 20_000,
    parameter int RESTORE_NS = 650_000
)
(
    // Pins from host, and supply from the bench
    input wire logic [12:0] addr_bus,
    input wire logic [7:0]  data_bus_o,
    input wire logic        data_bus_oe,
    input wire logic        chip_enable_n,
    input wire logic        write_enable_n,
    input wire logic        output_enable_n,
    input wire logic        supply_ok,
    // Data to host and counters
    output logic [7:0]      mem_q,
    output int              n_store,
    output int              n_recall,
    output int              n_viol
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [12:0] SEQ [5] = '{13'h0000, 13'h1555, 13'h0aaa, 13'h1fff, 13'h10f0};
    logic [7:0] mem [8192];
    logic [7:0] nv [8192];
    logic [7:0] last;
    logic       nv_busy;
    logic       st_abort;
    logic       drv;
    int         step;

    assign drv = !chip_enable_n && write_enable_n && !output_enable_n && !nv_busy;
    // Released lines show the inverse so a stale byte never reads as good
    assign mem_q = drv ? mem[addr_bus] : ~last;
    always @* if (drv) last = mem[addr_bus];

    initial
    begin
        n_store = 0; n_recall = 0; n_viol = 0; step = 0;
        nv_busy = 1'b1; st_abort = 1'b0; last = 8'h00;
        for (int i = 0; i < 8192; i++) nv[i] = i[7:0];
    end

    always @(posedge supply_ok)
    begin
        nv_busy = 1'b1;
        #RESTORE_NS;
        foreach (mem[i]) mem[i] = 8'h00;
        mem = nv;
        n_recall++;
        nv_busy = 1'b0;
    end

    always @(negedge supply_ok) st_abort = 1'b1;

    // Detection ignores output enable on purpose
    always @(negedge chip_enable_n)
    begin
        if (nv_busy) n_viol++;
        else if (!write_enable_n) step = 0;
        // Launch does not depend on how long the sixth pulse lasts
        else if (step == 5 && (addr_bus == 13'h0f0f || addr_bus == 13'h0f0e))
        begin
            nv_busy = 1'b1;
            st_abort = !supply_ok;
            step = 0;
            if (addr_bus == 13'h0f0f) fork
                begin
                    #STORE_NS;
                    if (!st_abort) begin nv = mem; n_store++; end
                    nv_busy = 1'b0;
                end
            join_none
            else fork
                begin
                    #RECALL_NS;
                    foreach (mem[i]) mem[i] = 8'h00;
                    mem = nv;
                    n_recall++;
                    nv_busy = 1'b0;
                end
            join_none
        end
        else if (step < 5 && addr_bus == SEQ[step]) step++;
        else step = (addr_bus == 13'h0000) ? 1 : 0;
    end

    always @(posedge chip_enable_n)
        if (!write_enable_n && data_bus_oe && !nv_busy) mem[addr_bus] = data_bus_o;
endmodule

`default_nettype wire

// file: tb/tb_nvsq_host.sv
// Bench for the nonvolatile sequence host against a behavioural memory.
// Assumes shortened store and restore waits; everything runs on core_clk.
`default_nettype none

module tb_nvsq_host;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, nrst, cmd_valid, supply_ok, cmd_ready, done, busy;
    logic data_bus_oe, chip_enable_n, write_enable_n, output_enable_n;
    nvsq_pkg::nvsq_op_t cmd_op;
    logic [12:0] cmd_addr, addr_bus;
    logic [7:0] cmd_wdata, rdata, data_bus_o, data_bus_i, mem_q;
    int n_store, n_recall, n_viol, fails, n_compared;

    assign data_bus_i = data_bus_oe ? data_bus_o : mem_q;

    nvsq_host #(.STORE_WAIT(50), .RESTORE_WAIT(20)) u_nvsq_host (.core_clk, .nrst, .cmd_valid,
        .cmd_op, .cmd_addr, .cmd_wdata, .cmd_ready, .done, .rdata, .busy, .supply_ok,
        .addr_bus, .data_bus_i, .data_bus_o, .data_bus_oe, .chip_enable_n, .write_enable_n,
        .output_enable_n);
    nvsq_mem_model #(.STORE_NS(1000), .RECALL_NS(20000), .RESTORE_NS(400)) u_nvsq_mem_model
        (.addr_bus, .data_bus_o, .data_bus_oe, .chip_enable_n, .write_enable_n,
        .output_enable_n, .supply_ok, .mem_q, .n_store, .n_recall, .n_viol);

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic do_cmd(input nvsq_pkg::nvsq_op_t op, input logic [12:0] a,
                          input logic [7:0] d);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 3000) begin @(posedge core_clk); #1; n++; end
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_wdata <= d;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        n = 0;
        do begin @(posedge core_clk); #1; n++; end while (done !== 1'b1 && n < 3000);
        check("done", 1'b1, done);
    endtask

    task automatic rd(input logic [12:0] a, input logic [7:0] exp);
        do_cmd(nvsq_pkg::NVSQ_OP_READ, a, 8'h00);
        check("rdata", exp, rdata);
    endtask

    task automatic t_power();
        @(posedge core_clk);
        supply_ok <= 1'b1;
        rd(13'h0042, 8'h42);
        check("recalls", 1, n_recall);
        $display("power-up test done");
    endtask

    task automatic t_rw();
        logic [12:0] a [3] = '{13'h0000, 13'h1fff, 13'h0f0f};
        foreach (a[i]) do_cmd(nvsq_pkg::NVSQ_OP_WRITE, a[i], 8'(8'h31 + i));
        foreach (a[i]) rd(a[i], 8'(8'h31 + i));
        $display("read write test done");
    endtask

    task automatic t_store();
        do_cmd(nvsq_pkg::NVSQ_OP_WRITE, 13'h0123, 8'ha5);
        do_cmd(nvsq_pkg::NVSQ_OP_STORE, 13'h0000, 8'h00);
        check("stores", 1, n_store);
        do_cmd(nvsq_pkg::NVSQ_OP_WRITE, 13'h0123, 8'h3c);
        rd(13'h0123, 8'h3c);
        do_cmd(nvsq_pkg::NVSQ_OP_RECALL, 13'h0000, 8'h00);
        check("recalls", 2, n_recall);
        rd(13'h0123, 8'ha5);
        rd(13'h0f0f, 8'h33);
        $display("store recall test done");
    endtask

    task automatic t_supply();
        @(posedge core_clk);
        supply_ok <= 1'b0;
        repeat (8) @(posedge core_clk);
        #1;
        check("cmd_ready", 1'b0, cmd_ready);
        check("busy", 1'b1, busy);
        @(posedge core_clk);
        supply_ok <= 1'b1;
        rd(13'h0123, 8'ha5);
        check("recalls", 3, n_recall);
        $display("supply test done");
    endtask

    initial
    begin
        fails = 0;
        n_compared = 0;
        nrst = 1'b0;
        supply_ok = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = nvsq_pkg::NVSQ_OP_READ;
        cmd_addr = 13'h0000;
        cmd_wdata = 8'h00;
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        t_power();
        t_rw();
        t_store();
        t_supply();
        check("early accesses", 0, n_viol);
        final_report();
    end

    // Whole run is near 1200 cycles; this leaves ample margin
    initial
    begin
        repeat (20000) @(posedge core_clk);
        fails++;
        final_report();
    end
endmodule

`default_nettype wire
